// ---- src/ldl_diag_core.v ----
// Diagnostics, loopback routing, interrupt source and transmit timing options block
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "ldl_defs.vh"
module ldl_diag_core (
  input  wire        clk,
  input  wire        rst_n,
  // AXI4-Lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Interrupt requests of the internal blocks (asynchronous levels)
  input  wire [6:0]  rxBlockIrq,
  input  wire [5:0]  txBlockIrq,
  // Clock sources, sampled on clk
  input  wire        txClockIn,
  input  wire        masterClockIn,
  input  wire        txClockInternal,
  input  wire        smoothClockJitter,
  // Datapath sources
  input  wire        backplaneTxData,
  input  wire        elasticStoreOut,
  input  wire        rxPcmData,
  input  wire        recoveredPos,
  input  wire        recoveredNeg,
  input  wire        txDataPos,
  input  wire        txDataNeg,
  input  wire        jitterRzPos,
  input  wire        jitterRzNeg,
  input  wire        slicerPos,
  input  wire        slicerNeg,
  input  wire        slicedTxPos,
  input  wire        slicedTxNeg,
  input  wire        framingBitSlot,
  input  wire        frameBitOneSlot,
  input  wire        xmitBitIn,
  // Outputs
  output reg         txClockOut,
  output reg         interruptOutN,
  output reg         xmitDataSelOut,
  output reg         backplaneRxPcm,
  output reg         jitterInPos,
  output reg         jitterInNeg,
  output reg         cdrInPos,
  output reg         cdrInNeg,
  output reg         basicTxOut,
  output reg         elasticTxAlign,
  output reg  [7:0]  timingOptions
);

  // ------------------------------------------------------------
  // Input synchronisers (two flops)
  // ------------------------------------------------------------
  reg [25:0] sync1_q;
  reg [25:0] sync2_q;
  wire [25:0] rawIn = {rxBlockIrq, txBlockIrq, txClockIn, masterClockIn, txClockInternal, smoothClockJitter,
                       backplaneTxData, elasticStoreOut, rxPcmData, recoveredPos, recoveredNeg,
                       jitterRzPos, jitterRzNeg, slicedTxPos, slicedTxNeg};
  always @(posedge clk) begin
    sync1_q <= rawIn;
    sync2_q <= sync1_q;
  end
  wire [6:0] rxIrqS   = sync2_q[25:19];
  wire [5:0] txIrqS   = sync2_q[18:13];
  wire       tclkInS  = sync2_q[12];
  wire       mclkInS  = sync2_q[11];
  wire       tclkIntS = sync2_q[10];
  wire       smoothS  = sync2_q[9];
  wire       btDataS  = sync2_q[8];
  wire       elstS    = sync2_q[7];
  wire       rxPcmS   = sync2_q[6];
  wire       recPosS  = sync2_q[5];
  wire       recNegS  = sync2_q[4];
  wire       jatPosS  = sync2_q[3];
  wire       jatNegS  = sync2_q[2];
  wire       sltPosS  = sync2_q[1];
  wire       sltNegS  = sync2_q[0];

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  reg [5:0] diag_q;
  reg [7:0] timing_q;
  wire payload_loopback_en  = diag_q[`LDL_DIAG_PAYLOAD_LOOPBACK_EN];
  wire line_loopback_en = diag_q[`LDL_DIAG_LINE_LOOPBACK_EN];
  wire metLb  = diag_q[`LDL_DIAG_METLB];
  wire digLb  = diag_q[`LDL_DIAG_DIGLB];
  wire mimic  = diag_q[`LDL_DIAG_MIMIC];
  wire supp   = diag_q[`LDL_DIAG_SUPP];

  // AXI write path: address and data taken in either order
  reg       awHeld_q;
  reg       wHeld_q;
  reg [7:0] awAddr_q;
  reg [31:0] wData_q;
  reg [3:0] wStrb_q;
  wire awTake = s_axi_awvalid & s_axi_awready;
  wire wTake  = s_axi_wvalid & s_axi_wready;
  wire haveAw = awHeld_q | awTake;
  wire haveW  = wHeld_q | wTake;
  wire [7:0]  wrAddr = awHeld_q ? awAddr_q : s_axi_awaddr;
  wire [31:0] wrData = wHeld_q ? wData_q : s_axi_wdata;
  wire [3:0]  wrStrb = wHeld_q ? wStrb_q : s_axi_wstrb;
  wire doWrite = haveAw & haveW & ~s_axi_bvalid;
  wire [7:0] wrIdx = {2'b00, wrAddr[7:2]};
  wire wrDiag  = doWrite & (wrIdx == `LDL_IDX_DIAG) & wrStrb[0];
  wire wrTime  = doWrite & (wrIdx == `LDL_IDX_TIMING) & wrStrb[0];
  wire wrMapped = (wrIdx == `LDL_IDX_DIAG) | (wrIdx == `LDL_IDX_TIMING) |
                  (wrIdx == `LDL_IDX_IRQ_RX) | (wrIdx == `LDL_IDX_IRQ_TX);

  // Write channel handshake and register storage
  always @(posedge clk) begin
    if (!rst_n) begin
      awHeld_q      <= 1'b0;
      wHeld_q       <= 1'b0;
      awAddr_q      <= 8'h00;
      wData_q       <= 32'h0000_0000;
      wStrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `LDL_AXI_OKAY;
      diag_q        <= `LDL_DIAG_RESET;
      timing_q      <= `LDL_TO_RESET;
    end else begin
      if (awTake) begin
        awAddr_q <= s_axi_awaddr;
      end
      if (wTake) begin
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_q     <= 1'b0;
        wHeld_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrMapped ? `LDL_AXI_OKAY : `LDL_AXI_SLVERR;
      end else begin
        awHeld_q <= haveAw;
        wHeld_q  <= haveW;
        if (s_axi_bvalid & s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
      s_axi_awready <= ~haveAw & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready  <= ~haveW & ~s_axi_wready & ~s_axi_bvalid;
      if (wrDiag) begin
        diag_q <= wrData[5:0];
      end
      if (wrTime) begin
        timing_q <= wrData[7:0];
      end
    end
  end

  // Read path; source registers are pure views, reading clears nothing
  reg [7:0] rdByte;
  reg       rdOk;
  always @* begin
    rdOk = 1'b1;
    case ({2'b00, s_axi_araddr[7:2]})
      `LDL_IDX_IRQ_RX: rdByte = {1'b0, rxIrqS};
      `LDL_IDX_IRQ_TX: rdByte = {2'b00, txIrqS};
      `LDL_IDX_DIAG:   rdByte = {2'b00, diag_q};
      `LDL_IDX_TIMING: rdByte = timing_q;
      default: begin
        rdByte = 8'h00;
        rdOk   = 1'b0;
      end
    endcase
  end

  // Read channel handshake
  always @(posedge clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `LDL_AXI_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rdByte};
        s_axi_rresp  <= rdOk ? `LDL_AXI_OKAY : `LDL_AXI_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Transmit clock output selection
  // ------------------------------------------------------------
  reg [2:0] div_q;
  reg       srcPrev_q;
  wire      ocsHi  = timing_q[`LDL_TO_OCS_HI];
  wire      ocsLo  = timing_q[`LDL_TO_OCS_LO];
  wire      srcSel = timing_q[`LDL_TO_SRCSEL];
  wire      smo    = timing_q[`LDL_TO_SMOOTH];
  wire      divSrc = srcSel ? mclkInS : tclkInS;
  wire      divRise = divSrc & ~srcPrev_q;
  always @(posedge clk) begin
    if (!rst_n) begin
      div_q      <= 3'h0;
      srcPrev_q  <= 1'b0;
      txClockOut <= 1'b0;
    end else begin
      srcPrev_q <= divSrc;
      if (divRise) begin
        div_q <= div_q + 3'h1;
      end
      if (ocsHi) begin
        txClockOut <= tclkIntS;                          // Internal transmit clock
      end else if (ocsLo) begin
        txClockOut <= tclkInS;
      end else if (smo) begin
        txClockOut <= div_q[2];
      end else begin
        txClockOut <= smoothS;
      end
    end
  end

  // ------------------------------------------------------------
  // Loopback routing and transmitter shaping
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      interruptOutN  <= 1'b1;
      xmitDataSelOut <= 1'b0;
      backplaneRxPcm <= 1'b1;
      jitterInPos    <= 1'b0;
      jitterInNeg    <= 1'b0;
      cdrInPos       <= 1'b0;
      cdrInNeg       <= 1'b0;
      basicTxOut     <= 1'b0;
      elasticTxAlign <= 1'b0;
      timingOptions  <= `LDL_TO_RESET;
    end else begin
      interruptOutN  <= ~(|rxIrqS | |txIrqS);
      xmitDataSelOut <= payload_loopback_en ? elstS : btDataS;
      elasticTxAlign <= payload_loopback_en;
      backplaneRxPcm <= payload_loopback_en ? 1'b1 : rxPcmS;
      jitterInPos    <= line_loopback_en ? recPosS : txDataPos;
      jitterInNeg    <= line_loopback_en ? recNegS : txDataNeg;
      if (digLb) begin
        cdrInPos <= jatPosS;
        cdrInNeg <= jatNegS;
      end else if (metLb) begin
        cdrInPos <= sltPosS;
        cdrInNeg <= sltNegS;
      end else begin
        cdrInPos <= slicerPos;
        cdrInNeg <= slicerNeg;
      end
      if (supp) begin
        basicTxOut <= 1'b0;
      end else if (mimic & frameBitOneSlot) begin
        basicTxOut <= framingBitSlot;
      end else begin
        basicTxOut <= xmitBitIn;
      end
      timingOptions <= timing_q;
    end
  end

endmodule

// ---- shared/ldl_defs.vh ----
// Register map, field positions, reset values and clocking constants of the diagnostics block
`ifndef LDL_DEFS_VH
`define LDL_DEFS_VH
// ----------------------------------------------------------------
// Register byte addresses (printed offsets are indices)
// ----------------------------------------------------------------
`define LDL_IDX_IRQ_RX      8'h08
`define LDL_IDX_IRQ_TX      8'h09
`define LDL_IDX_DIAG        8'h0A
`define LDL_IDX_TIMING      8'h07
`define LDL_ADDR_IRQ_RX     8'h20
`define LDL_ADDR_IRQ_TX     8'h24
`define LDL_ADDR_DIAG       8'h28
`define LDL_ADDR_TIMING     8'h1C
// ----------------------------------------------------------------
// Diagnostics register fields
// ----------------------------------------------------------------
`define LDL_DIAG_PAYLOAD_LOOPBACK_EN      5
`define LDL_DIAG_LINE_LOOPBACK_EN     4
`define LDL_DIAG_METLB      3
`define LDL_DIAG_DIGLB      2
`define LDL_DIAG_MIMIC      1
`define LDL_DIAG_SUPP       0
`define LDL_DIAG_RESET      6'h00
// ----------------------------------------------------------------
// Timing options register fields (own layout)
// ----------------------------------------------------------------
`define LDL_TO_SMOOTH       0
`define LDL_TO_SRCSEL       1
`define LDL_TO_PLL_LO       2
`define LDL_TO_PLL_HI       3
`define LDL_TO_OCS_LO       4
`define LDL_TO_OCS_HI       5
`define LDL_TO_XRATE        6
`define LDL_TO_HSBP         7
`define LDL_TO_RESET        8'h00
`define LDL_IRQ_RX_W        7
`define LDL_IRQ_TX_W        6
`define LDL_SMOOTH_DIV      3'h7
`define LDL_AXI_OKAY        2'b00
`define LDL_AXI_SLVERR      2'b10
`endif

// ---- tb/ldl_diag_core_assertions.sv ----
// Port-level assertions for the diagnostics block
`timescale 1ns/1ps
`include "ldl_defs.vh"
module ldl_diag_chk (
  input wire        clk,
  input wire        rst_n,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire [6:0]  rxBlockIrq,
  input wire [5:0]  txBlockIrq,
  input wire        txClockIn,
  input wire        txClockOut,
  input wire        interruptOutN,
  input wire        backplaneRxPcm,
  input wire        elasticTxAlign,
  input wire [7:0]  timingOptions
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // Multi-cycle preconditions
  // ----------------------------------------
  sequence irqHeld; (|{rxBlockIrq, txBlockIrq}) [*5]; endsequence
  sequence irqQuiet; !(|{rxBlockIrq, txBlockIrq}) [*5]; endsequence
  sequence directSel; (timingOptions[5:4] == 2'b01) [*4]; endsequence
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_irq_raised: assert property (irqHeld |-> !interruptOutN)
    else $error("interrupt output idle with a source pending");
  a_irq_quiet: assert property (irqQuiet |-> interruptOutN)
    else $error("interrupt output active with no source");
  a_direct_clk: assert property (directSel |-> txClockOut == $past(txClockIn, 3))
    else $error("clock out does not follow clock in");
  a_timing_reset: assert property ($rose(rst_n) |-> timingOptions == `LDL_TO_RESET)
    else $error("timing options not cleared by reset");
  a_pcm_forced: assert property (elasticTxAlign && $past(elasticTxAlign, 2) |-> backplaneRxPcm)
    else $error("receive pcm not forced high in payload loopback");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not returned one cycle after address");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  a_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == `LDL_AXI_SLVERR |-> s_axi_rdata == 32'h0000_0000)
    else $error("error read returns data");
endmodule
bind ldl_diag_core ldl_diag_chk ldl_diag_chk_inst (.clk, .rst_n, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp, .rxBlockIrq, .txBlockIrq, .txClockIn, .txClockOut,
  .interruptOutN, .backplaneRxPcm, .elasticTxAlign, .timingOptions);

// ---- tb/tb_ldl_diag_core.sv ----
// Self-checking bench for the diagnostics block
`timescale 1ns/1ps
`include "ldl_defs.vh"
module tb_ldl_diag_core;
  logic        clk = 0, rst_n = 0, tci = 0, prev;
  logic        awValid = 0, wValid = 0, bReady = 0, arValid = 0, rReady = 0;
  logic [7:0]  awAddr = 0, arAddr = 0, t;
  logic [31:0] wData = 0, r, seed = 32'h0000_0022;
  logic [6:0]  rxIrq = 0;
  logic [5:0]  txIrq = 0;
  logic [18:0] dp = 0;
  wire         awRdy, wRdy, bValid, arRdy, rValid, intN, xSel, pcm, jP, jN, cP, cN, bTx, align, tco;
  wire [1:0]   rResp, bResp;
  wire [7:0]   tOpt;
  wire [31:0]  rData;
  int          errors = 0, cmp_count = 0, i, k, cnt;
  logic [33:0] expQ[$];
  logic [1:0]  bQ[$];
  string       nameQ[$];
  ldl_diag_core ldl_diag_core_inst (
    .clk(clk), .rst_n(rst_n), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awRdy),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid), .s_axi_wready(wRdy),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arRdy), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady), .rxBlockIrq(rxIrq), .txBlockIrq(txIrq),
    .txClockIn(tci), .masterClockIn(dp[16]), .txClockInternal(dp[17]), .smoothClockJitter(dp[18]),
    .backplaneTxData(dp[0]), .elasticStoreOut(dp[1]), .rxPcmData(dp[2]), .recoveredPos(dp[3]),
    .recoveredNeg(dp[4]), .txDataPos(dp[5]), .txDataNeg(dp[6]), .jitterRzPos(dp[7]), .jitterRzNeg(dp[8]),
    .slicerPos(dp[9]), .slicerNeg(dp[10]), .slicedTxPos(dp[11]), .slicedTxNeg(dp[12]),
    .framingBitSlot(dp[13]), .frameBitOneSlot(dp[14]), .xmitBitIn(dp[15]), .txClockOut(tco),
    .interruptOutN(intN), .xmitDataSelOut(xSel), .backplaneRxPcm(pcm), .jitterInPos(jP),
    .jitterInNeg(jN), .cdrInPos(cP), .cdrInNeg(cN), .basicTxOut(bTx), .elasticTxAlign(align),
    .timingOptions(tOpt));
  // Clock
  always #5 clk = ~clk;
  // Random source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Comparison and counting
  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Bus write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = `LDL_AXI_OKAY);
    bQ.push_back(e);
    awAddr <= a;
    wData <= d;
    awValid <= 1;
    wValid <= 1;
    bReady <= 1;
    do begin
      @(posedge clk);
      if (awRdy) awValid <= 0;
      if (wRdy) wValid <= 0;
    end while (!bValid);
    bReady <= 0;
    @(posedge clk);
  endtask
  // Bus read, expectation noted for the monitor
  task automatic rd(input string nm, input logic [7:0] a, input logic [33:0] e);
    nameQ.push_back(nm);
    expQ.push_back(e);
    arAddr <= a;
    arValid <= 1;
    rReady <= 1;
    do begin
      @(posedge clk);
      if (arRdy) arValid <= 0;
    end while (!rValid);
    rReady <= 0;
    @(posedge clk);
  endtask
  // Monitor: each read answer and write response against the oldest note
  always @(posedge clk) begin
    if (rValid && rReady && nameQ.size() > 0) chk(nameQ.pop_front(), expQ.pop_front(), {rResp, rData});
    if (bValid && bReady && bQ.size() > 0) chk("write resp", bQ.pop_front(), bResp);
  end
  // Diagnostics setting with random line data
  task automatic lb(input logic [7:0] d);
    wr(`LDL_ADDR_DIAG, {24'h00_0000, d});
    rd("diag", `LDL_ADDR_DIAG, {28'h000_0000, d[5:0]});
    repeat (3) begin
      r = rnd();
      dp <= r[18:0];
      repeat (6) @(posedge clk);
      chk("pcm", d[5] | dp[2], pcm);
      chk("xsel", d[5] ? dp[1] : dp[0], xSel);
      chk("align", d[5], align);
      if (d[4]) chk("jitter in", dp[4:3], {jN, jP});
      else chk("jitter in", dp[6:5], {jN, jP});
      chk("cdr in", d[2] ? dp[8:7] : d[3] ? dp[12:11] : dp[10:9], {cN, cP});
      chk("basic tx", d[0] ? 1'b0 : (d[1] && dp[14]) ? dp[13] : dp[15], bTx);
    end
    $display("loopback test %h done", d);
  endtask
  // Verdict
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Watchdog
  initial begin
    #300us;
    errors++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    rd("diag reset", `LDL_ADDR_DIAG, 34'h0);
    rd("timing reset", `LDL_ADDR_TIMING, 34'h0);
    rd("unmapped", 8'h30, {`LDL_AXI_SLVERR, 32'h0000_0000});
    wr(8'h30, 32'h0000_00ff, `LDL_AXI_SLVERR);
    $display("reset test done");
    for (k = 0; k < 3; k++) begin
      r = rnd();
      rxIrq <= r[6:0];
      txIrq <= r[13:8];
      wr(`LDL_ADDR_IRQ_RX, 32'hffff_ffff);
      repeat (5) @(posedge clk);
      chk("irq out", !(|r[6:0] || |r[13:8]), intN);
      rd("irq rx", `LDL_ADDR_IRQ_RX, {27'h000_0000, r[6:0]});
      rd("irq rx again", `LDL_ADDR_IRQ_RX, {27'h000_0000, r[6:0]});
      rd("irq tx", `LDL_ADDR_IRQ_TX, {28'h000_0000, r[13:8]});
    end
    rxIrq <= 0;
    txIrq <= 0;
    repeat (6) @(posedge clk);
    chk("irq idle", 1'b1, intN);
    $display("interrupt test done");
    lb(8'h34);
    lb(8'h08);
    lb(8'h03);
    lb(8'hff);
    r = rnd();
    lb(r[7:0] | 8'h01);
    lb(8'h02);
    lb(8'h00);
    for (k = 0; k < 3; k++) begin
      t = (k == 0) ? 8'h10 : (k == 1) ? 8'h01 : 8'h03;
      wr(`LDL_ADDR_TIMING, {24'h00_0000, t});
      rd("timing", `LDL_ADDR_TIMING, {26'h000_0000, t});
      chk("timing out", t, tOpt);
      cnt = 0;
      prev = tco;
      for (i = 0; i < 296; i++) begin
        @(posedge clk);
        if (i % 2 == 0) dp[16] <= ~dp[16];
        if (i % 4 == 0) tci <= ~tci;
        if (i >= 40 && tco && !prev) cnt++;
        prev = tco;
      end
      chk("tx clock out", (k == 0) ? 32 : (k == 1) ? 4 : 8, cnt);
    end
    $display("timing test done");
    rst_n <= 0;
    repeat (10) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    rd("timing after reset", `LDL_ADDR_TIMING, 34'h0);
    rd("diag after reset", `LDL_ADDR_DIAG, 34'h0);
    chk("timing out reset", 8'h00, tOpt);
    chk("clock out default", dp[18], tco);
    $display("second reset test done");
    report_and_stop();
  end
endmodule
